// >>> logic/dasc_pkg.sv
package dasc_pkg;

    // ==========================================================
    // Frame layout
    localparam int FRAME_BITS = 56;
    localparam int HALF_BITS = 28;
    localparam int CODE_BITS = 8;
    localparam int P2_CODE_MSB = 35;
    localparam int P2_CODE_LSB = 28;
    localparam int P1_CODE_MSB = 7;
    localparam int P1_CODE_LSB = 0;
    localparam logic [7:0] CODE_RESET = 8'h00;
    localparam int SYNC_STAGES = 2;

    // ==========================================================
    // Synchronised link pins
    typedef struct packed {
        logic clk;
        logic cs_n;
        logic data;
    } dasc_link_s;

    // ==========================================================
    // Per-path outputs
    typedef struct packed {
        logic [7:0] code;
        logic dac_enable;
        logic vctl_oe;
        logic amp_off;
    } dasc_path_s;

endpackage

// >>> logic/dasc_sync.sv
`timescale 1ns/10ps
module dasc_sync (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Asynchronous pins in, synchronised copies out
    input wire dasc_pkg::dasc_link_s pins,
    output dasc_pkg::dasc_link_s synced
);
    typedef struct packed {
        dasc_pkg::dasc_link_s meta;
        dasc_pkg::dasc_link_s stable;
    } dasc_sync_s;

    dasc_sync_s state_r;
    dasc_sync_s state_nxt;

    always_comb begin
        state_nxt.meta = pins;
        state_nxt.stable = state_r.meta;
    end

    // Idle value: clock low, chip-select high
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= '{meta: '{clk: 1'b0, cs_n: 1'b1, data: 1'b0},
                         stable: '{clk: 1'b0, cs_n: 1'b1, data: 1'b0}};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign synced = state_r.stable;
endmodule

// >>> logic/dasc_top.sv
`timescale 1ns/10ps
module dasc_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Serial link pins
    input wire logic serial_clk,
    input wire logic serial_cs_n,
    input wire logic serial_data_in,
    // Static control pins
    input wire logic converter_select,
    input wire logic path1_amp_shutdown,
    input wire logic path2_amp_shutdown,
    input wire logic amp_low_supply_bias,
    // Path 1 outputs
    output logic [7:0] path1_code,
    output logic path1_dac_enable,
    output logic path1_control_voltage_pin_oe,
    output logic path1_amp_off,
    // Path 2 outputs
    output logic [7:0] path2_code,
    output logic path2_dac_enable,
    output logic path2_control_voltage_pin_oe,
    output logic path2_amp_off,
    // Status
    output logic amp_bias_low_supply,
    output logic frame_latched
);
    // ==========================================================
    // Synchronisers
    typedef struct packed {
        logic sel;
        logic pd1;
        logic pd2;
        logic bias;
    } dasc_static_s;

    typedef struct packed {
        logic [dasc_pkg::FRAME_BITS-1:0] shift;
        logic clk_d;
        logic cs_n_d;
        dasc_static_s st_meta;
        dasc_static_s st;
        dasc_pkg::dasc_path_s p1;
        dasc_pkg::dasc_path_s p2;
        logic bias;
        logic latched;
    } dasc_state_s;

    dasc_pkg::dasc_link_s link_pins;
    dasc_pkg::dasc_link_s link;
    dasc_state_s state_r;
    dasc_state_s state_nxt;

    assign link_pins = '{clk: serial_clk, cs_n: serial_cs_n,
                         data: serial_data_in};

    dasc_sync u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pins(link_pins),
        .synced(link)
    );

    // Path output from code and static pins
    function automatic dasc_pkg::dasc_path_s path_out(
        input logic [7:0] code,
        input logic sel,
        input logic pd
    );
        dasc_pkg::dasc_path_s p;
        p.code = code;
        p.dac_enable = sel;
        p.vctl_oe = sel;
        p.amp_off = pd;
        return p;
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        state_nxt = state_r;
        state_nxt.clk_d = link.clk;
        state_nxt.cs_n_d = link.cs_n;
        // Static pins are asynchronous too
        state_nxt.st_meta = '{sel: converter_select,
                              pd1: path1_amp_shutdown,
                              pd2: path2_amp_shutdown,
                              bias: amp_low_supply_bias};
        state_nxt.st = state_r.st_meta;
        // Shift only on rising clock with select low; oldest bit falls
        // out so an over-long frame keeps its last 56 bits.
        if (!link.cs_n && link.clk && !state_r.clk_d) begin
            state_nxt.shift = {
                state_r.shift[dasc_pkg::FRAME_BITS-2:0],
                link.data};
        end
        // Latch on select rising edge; upper half-word carries path 2
        if (link.cs_n && !state_r.cs_n_d) begin
            state_nxt.p2.code = state_r.shift[dasc_pkg::P2_CODE_MSB:
                                              dasc_pkg::P2_CODE_LSB];
            state_nxt.p1.code = state_r.shift[dasc_pkg::P1_CODE_MSB:
                                              dasc_pkg::P1_CODE_LSB];
            state_nxt.latched = 1'b1;
        end
        // Reserved bits 55..36 and 27..8 are ignored; host keeps them zero
        state_nxt.p1 = path_out(state_nxt.p1.code, state_r.st.sel,
                                state_r.st.pd1);
        state_nxt.p2 = path_out(state_nxt.p2.code, state_r.st.sel,
                                state_r.st.pd2);
        state_nxt.bias = state_r.st.bias;
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= '0;
            state_r.clk_d <= 1'b0;
            state_r.cs_n_d <= 1'b1;
            state_r.p1.code <= dasc_pkg::CODE_RESET;
            state_r.p2.code <= dasc_pkg::CODE_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign path1_code = state_r.p1.code;
    assign path1_dac_enable = state_r.p1.dac_enable;
    assign path1_control_voltage_pin_oe = state_r.p1.vctl_oe;
    assign path1_amp_off = state_r.p1.amp_off;
    assign path2_code = state_r.p2.code;
    assign path2_dac_enable = state_r.p2.dac_enable;
    assign path2_control_voltage_pin_oe = state_r.p2.vctl_oe;
    assign path2_amp_off = state_r.p2.amp_off;
    assign amp_bias_low_supply = state_r.bias;
    assign frame_latched = state_r.latched;
endmodule

// >>> verif/dasc_top_props.sv
`timescale 1ns/10ps
module dasc_top_props (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Watched pins
    input wire logic serial_cs_n,
    input wire logic converter_select,
    input wire logic path1_amp_shutdown,
    input wire logic path2_amp_shutdown,
    input wire logic [7:0] path1_code,
    input wire logic [7:0] path2_code,
    input wire logic path1_dac_enable,
    input wire logic path2_control_voltage_pin_oe,
    input wire logic path1_amp_off,
    input wire logic path2_amp_off,
    input wire logic frame_latched
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // ====
    // Frame latch
    sequence s_cs_up; $rose(serial_cs_n); endsequence
    property p_latch; s_cs_up |-> ##[3:5] frame_latched; endproperty
    a_latch: assert property (p_latch) else $error("no latch");
    property p_zero; !frame_latched |-> {path1_code, path2_code} == 16'h0000;
    endproperty
    a_zero: assert property (p_zero) else $error("early code");
    // Margin covers the pin synchroniser and the output register
    property p_low; !serial_cs_n [*6] |-> $stable({path1_code, path2_code});
    endproperty
    a_low: assert property (p_low) else $error("code moved in frame");
    property p_high; serial_cs_n [*8] |-> $stable({path1_code, path2_code});
    endproperty
    a_high: assert property (p_high) else $error("code moved idle");
    // ====
    // Static pins
    property p_amp1; $stable(path1_amp_shutdown) [*5]
        |-> path1_amp_off == path1_amp_shutdown; endproperty
    a_amp1: assert property (p_amp1) else $error("amp1 state");
    property p_amp2; $stable(path2_amp_shutdown) [*5]
        |-> path2_amp_off == path2_amp_shutdown; endproperty
    a_amp2: assert property (p_amp2) else $error("amp2 state");
    property p_dac; $stable(converter_select) [*5]
        |-> path1_dac_enable == converter_select; endproperty
    a_dac: assert property (p_dac) else $error("dac enable");
    property p_oe; $stable(converter_select) [*5]
        |-> path2_control_voltage_pin_oe == converter_select; endproperty
    a_oe: assert property (p_oe) else $error("pin drive");
endmodule
bind dasc_top dasc_top_props u_props (.*);

// >>> verif/dasc_host.sv
`timescale 1ns/10ps
module dasc_host (
    // Link pins
    output logic serial_clk,
    output logic serial_cs_n,
    output logic serial_data_in
);
    initial begin
        serial_clk = 1'b0;
        serial_cs_n = 1'b1;
        serial_data_in = 1'b0;
    end
    // Data moves on the falling clock edge, half a period ahead of the rising edge
    task automatic send(input logic [63:0] w, input int n, input real h);
        serial_cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_in = w[i];
            #h serial_clk = 1'b1;
            #h serial_clk = 1'b0;
        end
        #h serial_cs_n = 1'b1;
        serial_data_in = ~serial_data_in;
    endtask
    // Clock pulses with select high; the device must ignore them
    task automatic stray(input int n, input real h);
        for (int i = 0; i < n; i++) begin
            #h serial_clk = 1'b1;
            #h serial_clk = 1'b0;
        end
    endtask
endmodule

// >>> verif/dasc_top_tb.sv
`timescale 1ns/10ps
module dasc_top_tb;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic serial_clk, serial_cs_n, serial_data_in;
    logic converter_select = 1'b0, amp_low_supply_bias = 1'b0;
    logic path1_amp_shutdown = 1'b0, path2_amp_shutdown = 1'b0;
    logic [7:0] path1_code, path2_code;
    logic path1_dac_enable, path2_dac_enable, path1_amp_off, path2_amp_off;
    logic path1_control_voltage_pin_oe, path2_control_voltage_pin_oe;
    logic amp_bias_low_supply, frame_latched;
    // Odd entries carry four junk bits ahead of the frame
    logic [63:0] v [4] = '{64'h0000000a5000003c, 64'h0f0000081000007e,
        64'h0000000ff0000000, 64'h0a000000000000ff};
    int bad_count = 0;
    int checked = 0;
    always #5 ref_clk = ~ref_clk;
    dasc_host host (.*);
    dasc_top DUT (.*);
    task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        cmp({path1_code, path2_code, frame_latched}, 17'h0);
        foreach (v[i]) begin
            host.send(v[i], 56 + 4 * (i % 2), 62.5);
            repeat (10) @(negedge ref_clk);
            cmp({path1_code, path2_code, frame_latched},
                {v[i][7:0], v[i][35:28], 1'b1});
        end
        for (int m = 0; m < 16; m++) begin
            {converter_select, path1_amp_shutdown, path2_amp_shutdown,
                amp_low_supply_bias} = 4'(m);
            repeat (5) @(negedge ref_clk);
            cmp({10'h0, path1_dac_enable, path2_dac_enable,
                path1_control_voltage_pin_oe, path2_control_voltage_pin_oe,
                path1_amp_off, path2_amp_off, amp_bias_low_supply},
                {10'h0, {4{m[3]}}, m[2:0]});
        end
        // Stray clocks with select high, then an empty frame re-latches
        host.stray(8, 62.5);
        host.send(64'h0, 0, 62.5);
        repeat (10) @(negedge ref_clk);
        cmp({path1_code, path2_code, frame_latched}, 17'h1fe01);
        print_verdict();
    end
endmodule
